// file: flrh_top.sv
// Function-level reset handshake toward the application logic.
// Assumes config writes decoded elsewhere into strobes; all on application clock.
// Summary of operation
// [R1] PF FLR bit 15 write raises flag
// [R2] One flag bit per PF, bit0 PF0
// [R3] PF flag holds until matching done bit
// [R4] Application flushes PF transactions before done
// [R5] Application holds PF done one or more cycles
// [R6] Application answers PF within 100 ms
// [R7] VF FLR write gives one-cycle pulse; a write arriving while the pulse stands is dropped
// [R8] Pulse carries owning PF number
// [R9] Pulse carries VF offset
// [R10] Application flushes VF transactions before done
// [R11] Application gives single-cycle VF done pulse
// [R12] Application answers VF within 100 ms
// [R13] VF done carries owning PF number
// [R14] VF done carries VF offset
// [R15] Everything on the application clock
// [R16] Application clock not slower than core clock
// [R17] Clear flag after done; ignore idle dones
`timescale 1ns/10ps
module flrh_top (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // Configuration write strobes
  input  wire logic                         pf_cfg_wr,
  input  wire logic [flrh_pkg::PF_NUM_W-1:0] pf_cfg_num,
  input  wire logic                         vf_cfg_wr,
  input  wire logic [flrh_pkg::PF_NUM_W-1:0] vf_cfg_pf,
  input  wire logic [flrh_pkg::VF_OFF_W-1:0] vf_cfg_off,
  input  wire logic [flrh_pkg::DEVCTL_W-1:0] cfg_wdata,
  // Physical function handshake
  output logic [flrh_pkg::NUM_PF-1:0]       pf_reset_active,
  input  wire logic [flrh_pkg::NUM_PF-1:0]  pf_reset_done,
  // Virtual function handshake
  output logic                              vf_reset_received_pulse,
  output logic [flrh_pkg::PF_NUM_W-1:0]     vf_reset_owner_pf_out,
  output logic [flrh_pkg::VF_OFF_W-1:0]     vf_reset_offset_out,
  input  wire logic                         vf_reset_done_pulse,
  input  wire logic [flrh_pkg::PF_NUM_W-1:0] vf_done_owner_pf_in,
  input  wire logic [flrh_pkg::VF_OFF_W-1:0] vf_done_offset_in,
  // Status
  output logic                              vf_reset_pending
);
  logic                              pf_flr_hit;
  logic                              vf_flr_hit;
  logic                              pulse_q;
  logic [flrh_pkg::PF_NUM_W-1:0]     owner_q;
  logic [flrh_pkg::VF_OFF_W-1:0]     offset_q;
  logic                              done_match;
  flrh_pkg::flrh_vf_state_t          state_q;
  flrh_pkg::flrh_vf_state_t          state_d;

  assign pf_flr_hit = pf_cfg_wr && cfg_wdata[flrh_pkg::FLR_BIT];
  assign vf_flr_hit = vf_cfg_wr && cfg_wdata[flrh_pkg::FLR_BIT];

  // Per-PF flags, bit n belongs to PF n
  for (genvar i = 0; i < flrh_pkg::NUM_PF; i++) begin : g_pf
    flrh_pf_slot u_slot (
      .clk      (clk),
      .nrst     (nrst),
      .flr_set  (pf_flr_hit && (pf_cfg_num == flrh_pkg::PF_NUM_W'(i))), // R2
      .done_in  (pf_reset_done[i]),
      .active_q (pf_reset_active[i])
    );
  end

  // VF event tracker; done accepted only while a VF reset is outstanding
  assign done_match = vf_reset_done_pulse && (vf_done_owner_pf_in == owner_q)
                      && (vf_done_offset_in == offset_q); // R13 R14

  always_comb begin
    state_d = state_q;
    case (state_q)
      flrh_pkg::FLRH_IDLE: begin
        if (vf_flr_hit) begin
          state_d = flrh_pkg::FLRH_PULSE;
        end
      end
      // An answer may already come while the pulse stands
      flrh_pkg::FLRH_PULSE: begin
        if (done_match) begin
          state_d = flrh_pkg::FLRH_IDLE;    // R11
        end else begin
          state_d = flrh_pkg::FLRH_WAIT;    // R7
        end
      end
      flrh_pkg::FLRH_WAIT: begin
        if (vf_flr_hit) begin
          state_d = flrh_pkg::FLRH_PULSE;
        end else if (done_match) begin
          state_d = flrh_pkg::FLRH_IDLE;
        end
      end
      default: begin
        state_d = flrh_pkg::FLRH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= flrh_pkg::FLRH_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= vf_flr_hit && (state_q != flrh_pkg::FLRH_PULSE); // R7
    end
  end

  // Identifiers captured with the write, stable through the pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      owner_q  <= '0;
      offset_q <= '0;
    end else if (vf_flr_hit && (state_q != flrh_pkg::FLRH_PULSE)) begin
      owner_q  <= vf_cfg_pf;                // R8
      offset_q <= vf_cfg_off;               // R9
    end
  end

  assign vf_reset_received_pulse = pulse_q;
  assign vf_reset_owner_pf_out   = owner_q;
  assign vf_reset_offset_out     = offset_q;
  assign vf_reset_pending        = (state_q != flrh_pkg::FLRH_IDLE);

  // Steps of the VF handshake
  sequence vf_write_s;
    vf_flr_hit && state_q != flrh_pkg::FLRH_PULSE;
  endsequence

  sequence vf_one_pulse_s;
    vf_reset_received_pulse ##1 !vf_reset_received_pulse;
  endsequence

  sequence vf_done_s;
    done_match && !vf_flr_hit && state_q != flrh_pkg::FLRH_IDLE;
  endsequence

  sequence vf_idle_s;
    !vf_reset_pending && !vf_flr_hit;
  endsequence

  // VF request side
  vf_pulse_once_a: assert property (@(posedge clk) disable iff (!nrst)
    vf_write_s |=> vf_one_pulse_s) else $error("vf pulse not single"); // R7

  vf_owner_out_a: assert property (@(posedge clk) disable iff (!nrst)
    vf_write_s |=> vf_reset_owner_pf_out == $past(vf_cfg_pf)) else $error("bad owner"); // R8

  vf_offset_out_a: assert property (@(posedge clk) disable iff (!nrst)
    vf_write_s |=> vf_reset_offset_out == $past(vf_cfg_off)) else $error("bad offset"); // R9

  vf_no_spurious_a: assert property (@(posedge clk) disable iff (!nrst)
    vf_reset_received_pulse |-> $past(vf_flr_hit)) else $error("pulse without write"); // R7

  vf_pend_rise_a: assert property (@(posedge clk) disable iff (!nrst)
    vf_write_s |=> vf_reset_pending) else $error("vf pending not set"); // R7

  vf_pulse_state_a: assert property (@(posedge clk) disable iff (!nrst)
    vf_reset_received_pulse |-> state_q == flrh_pkg::FLRH_PULSE)
    else $error("pulse outside pulse state"); // R7

  vf_pulse_gap_a: assert property (@(posedge clk) disable iff (!nrst)
    vf_reset_received_pulse && vf_flr_hit |=> !vf_reset_received_pulse)
    else $error("back to back pulse"); // R7

  vf_idle_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    vf_idle_s |=> !vf_reset_pending && !vf_reset_received_pulse)
    else $error("vf activity while idle"); // R7

  vf_ids_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !(vf_flr_hit && state_q != flrh_pkg::FLRH_PULSE)
    |=> $stable(vf_reset_owner_pf_out) && $stable(vf_reset_offset_out))
    else $error("vf ids changed"); // R8 R9

  // VF answer side
  vf_done_close_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == flrh_pkg::FLRH_WAIT && done_match && !vf_flr_hit |=> !vf_reset_pending)
    else $error("vf done ignored"); // R14

  vf_done_taken_a: assert property (@(posedge clk) disable iff (!nrst)
    vf_done_s |=> !vf_reset_pending) else $error("vf done not taken"); // R13 R14

  vf_wrong_done_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == flrh_pkg::FLRH_WAIT && vf_reset_done_pulse && !done_match && !vf_flr_hit
    |=> vf_reset_pending) else $error("vf done with wrong ids"); // R14

  vf_wait_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == flrh_pkg::FLRH_WAIT && !vf_reset_done_pulse && !vf_flr_hit
    |=> vf_reset_pending) else $error("vf pending dropped"); // R11

  // PF flags
  pf_flag_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (pf_reset_active & ~pf_reset_done) == pf_reset_active && !pf_flr_hit
    |=> (pf_reset_active & $past(pf_reset_active)) == $past(pf_reset_active))
    else $error("pf flag dropped"); // R3

  pf_idle_done_a: assert property (@(posedge clk) disable iff (!nrst)
    pf_reset_active == '0 && !pf_flr_hit |=> pf_reset_active == '0)
    else $error("flag from done alone"); // R17

  pf_write_hit_a: assert property (@(posedge clk) disable iff (!nrst)
    pf_flr_hit && pf_cfg_num < 3'(flrh_pkg::NUM_PF)
    |=> pf_reset_active[$past(pf_cfg_num[1:0])]) else $error("pf flag missing"); // R1 R2

  pf_high_num_a: assert property (@(posedge clk) disable iff (!nrst)
    pf_flr_hit && pf_cfg_num >= 3'(flrh_pkg::NUM_PF) && pf_reset_active == '0
    |=> pf_reset_active == '0) else $error("flag for absent pf"); // R2

  pf_done_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (pf_reset_active & pf_reset_done) != '0 && !pf_flr_hit
    |=> (pf_reset_active & $past(pf_reset_active & pf_reset_done)) == '0)
    else $error("pf flag not cleared"); // R17

  // Reset values
  pf_reset_val_a: assert property (@(posedge clk)
    !nrst |-> pf_reset_active == flrh_pkg::PF_ACTIVE_RST) else $error("reset value"); // R15

  vf_reset_out_a: assert property (@(posedge clk)
    !nrst |-> !vf_reset_received_pulse && !vf_reset_pending)
    else $error("vf reset value"); // R15
endmodule

// file: flrh_pkg.sv
// Package for the function-level reset handshake block.
// Assumes one application clock domain; widths fixed at full documented range.
package flrh_pkg;
  localparam int unsigned NUM_PF       = 4;
  localparam int unsigned PF_NUM_W     = 3;
  localparam int unsigned VF_OFF_W     = 11;
  localparam int unsigned FLR_BIT      = 15;
  localparam int unsigned DEVCTL_W     = 16;
  localparam int unsigned MAX_VF_PEND  = 8;
  localparam int unsigned CLK_MHZ      = 10;
  localparam int unsigned DONE_TIME_MS = 100;
  localparam int unsigned DONE_CYCLES  = DONE_TIME_MS * 1000 * CLK_MHZ;
  localparam logic [NUM_PF-1:0] PF_ACTIVE_RST = 4'h0;

  typedef enum logic [1:0] {
    FLRH_IDLE  = 2'b00,
    FLRH_PULSE = 2'b01,
    FLRH_WAIT  = 2'b11
  } flrh_vf_state_t;
endpackage

// file: flrh_pf_slot.sv
// One physical function's reset-active flag.
// Assumes configuration writes arrive as single-cycle strobes.
`timescale 1ns/10ps
module flrh_pf_slot (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Event and answer
  input  wire logic flr_set,
  input  wire logic done_in,
  // Flag
  output logic      active_q
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_q <= 1'b0;
    end else if (flr_set) begin
      active_q <= 1'b1;                     // R1
    end else if (active_q && done_in) begin
      active_q <= 1'b0;                     // R17
    end
  end

  hold_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    active_q && !done_in |=> active_q) else $error("flag dropped early"); // R3
  clear_done_a: assert property (@(posedge clk) disable iff (!nrst)
    active_q && done_in && !flr_set |=> !active_q) else $error("flag not cleared"); // R17
  raise_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    flr_set |=> active_q) else $error("flag not raised"); // R1
endmodule

// file: flrh_app_model.sv
// Behavioural model of the application logic that answers reset requests.
// Assumes the handshake block on the same clock; answers after wait_cyc cycles.
`timescale 1ns/10ps
module flrh_app_model (
  // Clock, reset and answer delay
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  wait_cyc,
  // From the block
  input  wire logic [3:0]  pf_active,
  input  wire logic        vf_pulse,
  input  wire logic [2:0]  vf_pf,
  input  wire logic [10:0] vf_off,
  // Answers
  output logic [3:0]       pf_done = 4'h0,
  output logic             vf_done = 1'b0,
  output logic [2:0]       done_pf = 3'h0,
  output logic [10:0]      done_off = 11'h0
);
  logic [2:0]  pf_s;
  logic [10:0] off_s;

  always begin
    @(negedge clk);
    if (nrst && pf_active != 4'h0) begin
      repeat (wait_cyc) @(negedge clk);
      pf_done = pf_active;
      repeat (2) @(negedge clk);
      pf_done = 4'h0;
    end
  end

  always begin
    @(negedge clk);
    if (nrst && vf_pulse === 1'b1) begin
      pf_s = vf_pf;
      off_s = vf_off;
      repeat (wait_cyc) @(negedge clk);
      done_pf = pf_s;
      done_off = off_s;
      vf_done = 1'b1;
      @(negedge clk);
      vf_done = 1'b0;
      done_pf = ~pf_s;
      done_off = ~off_s;
    end
  end
endmodule

// file: flrh_top_tb.sv
// Self-checking testbench for the reset handshake block.
// Assumes flrh_app_model stands in for the application logic.
`timescale 1ns/10ps
module flrh_top_tb;
  logic        clk = 1'b0, nrst = 1'b1, pf_wr = 1'b0, vf_wr = 1'b0;
  logic [2:0]  pf_num = 3'h0, vf_pf = 3'h0, own_pf, dn_pf;
  logic [10:0] vf_off = 11'h0, own_off, dn_off;
  logic [15:0] wdata = 16'h0;
  logic [3:0]  active, mdl_done, extra_done = 4'h0, wait_cyc = 4'h0;
  logic        pulse, dn_pulse, pending;
  int          miscompares = 0, num_checks = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  flrh_top dut_u (.clk(clk), .nrst(nrst), .pf_cfg_wr(pf_wr), .pf_cfg_num(pf_num),
    .vf_cfg_wr(vf_wr), .vf_cfg_pf(vf_pf), .vf_cfg_off(vf_off), .cfg_wdata(wdata),
    .pf_reset_active(active), .pf_reset_done(mdl_done | extra_done),
    .vf_reset_received_pulse(pulse), .vf_reset_owner_pf_out(own_pf),
    .vf_reset_offset_out(own_off), .vf_reset_done_pulse(dn_pulse),
    .vf_done_owner_pf_in(dn_pf), .vf_done_offset_in(dn_off), .vf_reset_pending(pending));

  flrh_app_model app_u (.clk(clk), .nrst(nrst), .wait_cyc(wait_cyc), .pf_active(active),
    .vf_pulse(pulse), .vf_pf(own_pf), .vf_off(own_off), .pf_done(mdl_done),
    .vf_done(dn_pulse), .done_pf(dn_pf), .done_off(dn_off));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cfg_write(input logic is_vf, input logic [2:0] pf, input logic [15:0] d);
    @(negedge clk);
    pf_wr = ~is_vf;
    vf_wr = is_vf;
    pf_num = pf;
    vf_pf = pf;
    wdata = d;
    @(negedge clk);
    pf_wr = 1'b0;
    vf_wr = 1'b0;
  endtask

  // Bounded wait for all handshakes to settle
  task automatic wait_idle();
    int n = 0;
    while ((active !== 4'h0 || pending !== 1'b0) && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("flags idle", 16'h0, {11'h0, active, pending});
    if (n == 40) stop_test();
  endtask

  task automatic t_pf();
    wait_cyc = 4'h5;
    for (int i = 0; i < 4; i += 3) begin
      cfg_write(1'b0, i[2:0], 16'h8000);
      check("pf flag", 16'h1 << i, {12'h0, active});
      repeat (3) @(negedge clk);
      check("pf flag held", 16'h1 << i, {12'h0, active});
      wait_idle();
    end
  endtask

  task automatic t_quiet();
    extra_done = 4'hf;
    cfg_write(1'b0, 3'h1, 16'h7fff);
    check("pf no flr", 16'h0, {12'h0, active});
    extra_done = 4'h4;
    cfg_write(1'b0, 3'h2, 16'h8000);
    check("pf set wins", 16'h4, {12'h0, active});
    extra_done = 4'h0;
    wait_idle();
  endtask

  task automatic t_vf();
    for (int w = 0; w < 8; w += 4) begin
      wait_cyc = w[3:0];
      vf_off = 11'h7ff - w[10:0];
      cfg_write(1'b1, 3'h5, 16'h8000);
      check("vf pulse", 16'h1, {15'h0, pulse});
      check("vf owner", 16'h5, {13'h0, own_pf});
      check("vf offset", 16'h07ff - w[15:0], {5'h0, own_off});
      check("vf pending", 16'h1, {15'h0, pending});
      @(negedge clk);
      check("vf pulse end", 16'h0, {15'h0, pulse});
      wait_idle();
    end
  endtask

  task automatic t_reset();
    wait_cyc = 4'h9;
    cfg_write(1'b0, 3'h2, 16'h8000);
    cfg_write(1'b1, 3'h1, 16'h8000);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    check("reset outputs", 16'h0, {10'h0, active, pulse, pending});
    nrst = 1'b1;
    @(negedge clk);
    check("after reset", 16'h0, {10'h0, active, pulse, pending});
    repeat (12) @(negedge clk);
    wait_idle();
  endtask

  initial begin
    #10 nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_pf();
    t_quiet();
    t_vf();
    t_reset();
    stop_test();
  end
endmodule
